/* File: src/t1_payload_params.svh */
// register offsets, field positions, reset values and timing counts of the payload control bank
`ifndef T1_PAYLOAD_PARAMS_SVH
`define T1_PAYLOAD_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_TX_CFG        8'hCB
`define IDX_TX_ENABLE     8'hCC
`define IDX_RX_STATUS     8'hCD
`define IDX_RX_CONTROL    8'hCE
`define IDX_RX_DATA       8'hCF
`define IDX_RX_CFG        8'hD0

// configuration, enable and control register fields
`define CFG_SNAP_BIT      7
`define CFG_GSTRK_BIT     6
`define CFG_SUPP_MSB      5
`define CFG_SUPP_LSB      3
`define CFG_GSUB_MSB      2
`define CFG_GSUB_LSB      0
`define ENA_POS_BIT       3
`define ENA_ON_BIT        0
`define CTL_DIR_BIT       7

// reset values and write masks
`define TX_CFG_RESET      8'h80
`define RX_CFG_RESET      8'h80
`define TX_ENABLE_RESET   8'h00
`define TX_ENABLE_MASK    8'h09
`define RX_CFG_MASK       8'hC7

// zero code suppression selector codes
`define SUPP_NONE         3'h0
`define SUPP_FILL8        3'h1
`define SUPP_JAM8         3'h2
`define SUPP_FILL7        3'h3
`define SUPP_DDS          3'h4
`define DDS_BYTE          8'h98

// milliwatt pattern bytes: outer for phases 0 and 3, inner for 1 and 2
`define MW_ALAW_OUTER     8'h34
`define MW_ALAW_INNER     8'h21
`define MW_ULAW_OUTER     8'h1E
`define MW_ULAW_INNER     8'h0B

// substitution selector codes
`define SUB_NONE          3'h0
`define SUB_TRUNK         3'h1
`define SUB_ALAW          3'h2
`define SUB_ULAW          3'h3
`define SUB_LOOP          3'h4

// indirect banks, selected by address bits 6:5
`define BANK_CHSEL        2'h0
`define BANK_TRUNK        2'h1
`define BANK_SIG          2'h2
`define SIG_STRK_BIT      4

// clock cycles the indirect engine stays busy after a control write
`define IND_BUSY_CYCLES   2

`endif

/* File: src/t1_payload_pkg.sv */
// types shared by the payload control bank and its surroundings
package t1_payload_pkg;

    typedef struct packed {
        logic       valid;
        logic [4:0] channel;     // 0 .. 23
        logic [7:0] data;
        logic [7:0] sig_byte;    // transmit_signaling_input for this channel
        logic       framed;      // SF or ESF format active
        logic       sf_start;    // first frame of the superframe
        logic       sig_frame;   // this frame carries signaling
        logic [1:0] sig_sel;     // 0 = A .. 3 = D
    } tx_in_s;

    typedef struct packed {
        logic [2:0] chan_sel;
        logic [7:0] trunk_code;
        logic       trunk_sig_en;
        logic [3:0] sig_code;
    } tx_chan_cfg_s;

    typedef struct packed {
        logic       valid;
        logic [4:0] channel;
        logic [7:0] data;
        logic [3:0] sig;         // extracted ABCD
        logic       sf_start;
        logic       sf_sync;     // superframe synchronised
    } rx_in_s;

    typedef struct packed {
        logic       valid;
        logic [4:0] channel;
        logic [7:0] data;
    } tx_out_s;

    typedef struct packed {
        logic       valid;
        logic [4:0] channel;
        logic [7:0] data;
        logic [3:0] sig;         // receive_signaling_output
    } rx_out_s;

    typedef enum logic { ind_idle, ind_busy } ind_state_e;

endpackage

/* File: src/t1_payload_control_config.sv */
// payload control configuration bank, receive indirect access engine and per-channel byte datapath
`timescale 1ns/1ps
`include "t1_payload_params.svh"
module t1_payload_control_config #(
    parameter int CHANNELS    = 24,
    parameter int BUSY_CYCLES = `IND_BUSY_CYCLES
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire t1_payload_pkg::tx_in_s       tx_in,
    input  wire t1_payload_pkg::tx_chan_cfg_s tx_cfg,
    input  wire logic [7:0]                   loopback_data,
    input  wire t1_payload_pkg::rx_in_s       rx_in,
    output t1_payload_pkg::tx_out_s           tx_out,
    output t1_payload_pkg::rx_out_s           rx_out
);
    import t1_payload_pkg::*;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic       wr_pend;
    logic [7:0] wr_idx;
    logic       acc;
    logic [7:0] a_idx;
    logic       wr_now;
    logic [7:0] wd;

    assign acc    = hsel && htrans[1] && hready;
    assign a_idx  = haddr[9:2];
    assign wr_now = wr_pend;
    assign wd     = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_idx    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= acc && hwrite && (haddr[31:10] == 22'h000000);
            wr_idx    <= a_idx;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // direct registers
    // ------------------------------------------------------------
    logic [7:0] tx_cfg_reg;
    logic [7:0] tx_ena_reg;
    logic [7:0] rx_cfg_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_cfg_reg <= `TX_CFG_RESET;
            tx_ena_reg <= `TX_ENABLE_RESET;
            rx_cfg_reg <= `RX_CFG_RESET;
        end else if (wr_now) begin
            if (wr_idx == `IDX_TX_CFG) begin
                tx_cfg_reg <= wd;
            end
            if (wr_idx == `IDX_TX_ENABLE) begin
                tx_ena_reg <= wd & `TX_ENABLE_MASK;
            end
            if (wr_idx == `IDX_RX_CFG) begin
                rx_cfg_reg <= wd & `RX_CFG_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // receive indirect access engine
    // ------------------------------------------------------------
    ind_state_e state;
    logic [7:0] ctl_reg;
    logic [7:0] data_reg;
    logic [3:0] busy_cnt;
    logic [7:0] chsel_mem [CHANNELS];
    logic [7:0] trunk_mem [CHANNELS];
    logic [7:0] sig_mem   [CHANNELS];
    logic       ind_ok;
    logic [4:0] ind_ch;
    logic [1:0] ind_bank;
    logic [7:0] ind_rd;
    logic       busy;
    logic       done;

    assign busy     = (state == ind_busy);
    assign done     = busy && (busy_cnt == 4'h1);
    assign ind_bank = ctl_reg[6:5];
    assign ind_ch   = ctl_reg[4:0] - 5'h01;
    assign ind_ok   = (ind_bank != 2'h3) && (ctl_reg[4:0] != 5'h00) && (int'(ctl_reg[4:0]) <= CHANNELS);

    always_comb begin
        ind_rd = 8'h00;
        if (ind_ok) begin
            unique case (ind_bank)
                `BANK_CHSEL: ind_rd = chsel_mem[ind_ch];
                `BANK_TRUNK: ind_rd = trunk_mem[ind_ch];
                default:     ind_rd = sig_mem[ind_ch];
            endcase
        end
    end

    // a control write while busy is dropped so the running transfer keeps its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= ind_idle;
            ctl_reg  <= 8'h00;
            busy_cnt <= 4'h0;
        end else begin
            unique case (state)
                ind_idle: begin
                    if (wr_now && wr_idx == `IDX_RX_CONTROL) begin
                        ctl_reg  <= wd;
                        busy_cnt <= 4'(BUSY_CYCLES);
                        state    <= ind_busy;
                    end
                end
                ind_busy: begin
                    busy_cnt <= busy_cnt - 4'h1;
                    if (done) begin
                        state <= ind_idle;
                    end
                end
            endcase
        end
    end

    // data register: host load, or filled by a finished read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_reg <= 8'h00;
        end else if (done && ctl_reg[`CTL_DIR_BIT]) begin
            data_reg <= ind_rd;
        end else if (wr_now && wr_idx == `IDX_RX_DATA && !busy) begin
            data_reg <= wd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                chsel_mem[i] <= 8'h00;
                trunk_mem[i] <= 8'h00;
                sig_mem[i]   <= 8'h00;
            end
        end else if (done && !ctl_reg[`CTL_DIR_BIT] && ind_ok) begin
            unique case (ind_bank)
                `BANK_CHSEL: chsel_mem[ind_ch] <= data_reg;
                `BANK_TRUNK: trunk_mem[ind_ch] <= data_reg;
                default:     sig_mem[ind_ch]   <= data_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data, registered in the address phase
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        unique case (a_idx)
            `IDX_TX_CFG:     rd_byte = tx_cfg_reg;
            `IDX_TX_ENABLE:  rd_byte = tx_ena_reg;
            `IDX_RX_STATUS:  rd_byte = {7'h00, busy};
            `IDX_RX_CONTROL: rd_byte = ctl_reg;
            `IDX_RX_DATA:    rd_byte = data_reg;
            `IDX_RX_CFG:     rd_byte = rx_cfg_reg;
            default:         rd_byte = 8'h00;
        endcase
        if (haddr[31:10] != 22'h000000) begin
            rd_byte = 8'h00;
        end
    end

    // a read right after a write to the same register sees the old value of the written one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (acc && !hwrite) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // shared byte functions
    // ------------------------------------------------------------
    function automatic logic [7:0] milliwatt(input logic alaw, input logic [2:0] ph);
        logic [7:0] r;
        r = 8'h00;
        unique case (ph[1:0])
            2'h0, 2'h3: r = alaw ? `MW_ALAW_OUTER : `MW_ULAW_OUTER;
            default:    r = alaw ? `MW_ALAW_INNER : `MW_ULAW_INNER;
        endcase
        if (ph[2]) begin
            r = r | 8'h80;
        end
        return r;
    endfunction

    function automatic logic [7:0] replace(input logic [2:0] sel, input logic [7:0] d,
                                           input logic [7:0] trunk, input logic [7:0] lb,
                                           input logic [2:0] ph, input logic tx_side);
        logic [7:0] r;
        r = d;
        case (sel)
            `SUB_TRUNK: r = trunk;
            `SUB_ALAW:  r = milliwatt(1'b1, ph);
            `SUB_ULAW:  r = milliwatt(1'b0, ph);
            `SUB_LOOP:  r = tx_side ? lb : d;
            default:    r = d;
        endcase
        return r;
    endfunction

    // data[0] is channel bit 8, data[1] is bit 7
    function automatic logic [7:0] suppress(input logic [2:0] code, input logic [7:0] d,
                                            input logic sig_frame);
        logic [7:0] r;
        r = d;
        case (code)
            `SUPP_FILL8: if (d == 8'h00) r = sig_frame ? 8'h02 : 8'h01;
            `SUPP_JAM8:  r = d | 8'h01;
            `SUPP_FILL7: if (d == 8'h00) r = 8'h02;
            `SUPP_DDS:   if (d == 8'h00) r = `DDS_BYTE;
            default:   r = d;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // transmit datapath
    // ------------------------------------------------------------
    logic [3:0] tx_snap [CHANNELS];
    logic [2:0] tx_phase;
    logic       tx_ch_ok;
    logic [3:0] tx_live;
    logic [3:0] tx_nib;
    logic [2:0] tx_sel;
    logic [7:0] tx_d;
    logic [2:0] tx_gsub;

    assign tx_ch_ok = int'(tx_in.channel) < CHANNELS;
    assign tx_gsub  = tx_cfg_reg[`CFG_GSUB_MSB:`CFG_GSUB_LSB];

    always_comb begin
        tx_live = tx_ena_reg[`ENA_POS_BIT] ? {tx_in.sig_byte[3:2], 2'b00}
                                            : tx_in.sig_byte[3:0];
        tx_nib = tx_live;
        if (tx_cfg_reg[`CFG_SNAP_BIT] && tx_in.framed && !tx_in.sf_start && tx_ch_ok) begin
            tx_nib = tx_snap[tx_in.channel];
        end
        if (tx_cfg_reg[`CFG_GSTRK_BIT] || tx_cfg.trunk_sig_en) begin
            tx_nib = tx_cfg.sig_code;
        end
        tx_sel = (tx_gsub == `SUB_NONE) ? tx_cfg.chan_sel : tx_gsub;
        tx_d   = replace(tx_sel, tx_in.data, tx_cfg.trunk_code, loopback_data, tx_phase, 1'b1);
        if (tx_in.sig_frame) begin
            tx_d[0] = tx_nib[2'd3 - tx_in.sig_sel];
        end
        tx_d = suppress(tx_cfg_reg[`CFG_SUPP_MSB:`CFG_SUPP_LSB], tx_d, tx_in.sig_frame);
        if (!tx_ena_reg[`ENA_ON_BIT]) begin
            tx_d = tx_in.data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                tx_snap[i] <= 4'h0;
            end
        end else if (tx_in.valid && tx_in.sf_start && tx_ch_ok) begin
            tx_snap[tx_in.channel] <= tx_live;
        end
    end

    // milliwatt phase steps once per frame, after the last channel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_phase <= 3'h0;
        end else if (tx_in.valid && int'(tx_in.channel) == CHANNELS - 1) begin
            tx_phase <= tx_phase + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_out <= '0;
        end else begin
            tx_out.valid   <= tx_in.valid;
            tx_out.channel <= tx_in.channel;
            tx_out.data    <= tx_d;
        end
    end

    // ------------------------------------------------------------
    // receive datapath
    // ------------------------------------------------------------
    logic [3:0] rx_snap [CHANNELS];
    logic [2:0] rx_phase;
    logic       rx_ch_ok;
    logic [4:0] rx_ch;
    logic [3:0] rx_nib;
    logic [2:0] rx_sel;
    logic [7:0] rx_d;
    logic [2:0] rx_gsub;

    assign rx_ch_ok = int'(rx_in.channel) < CHANNELS;
    assign rx_ch    = rx_ch_ok ? rx_in.channel : 5'h00;
    assign rx_gsub  = rx_cfg_reg[`CFG_GSUB_MSB:`CFG_GSUB_LSB];

    always_comb begin
        rx_nib = rx_in.sig;
        if (rx_cfg_reg[`CFG_SNAP_BIT] && rx_in.sf_sync && !rx_in.sf_start) begin
            rx_nib = rx_snap[rx_ch];
        end
        if (rx_cfg_reg[`CFG_GSTRK_BIT] || sig_mem[rx_ch][`SIG_STRK_BIT]) begin
            rx_nib = sig_mem[rx_ch][3:0];
        end
        rx_sel = (rx_gsub == `SUB_NONE) ? chsel_mem[rx_ch][7:5] : rx_gsub;
        rx_d   = replace(rx_sel, rx_in.data, trunk_mem[rx_ch], 8'h00, rx_phase, 1'b0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                rx_snap[i] <= 4'h0;
            end
        end else if (rx_in.valid && rx_in.sf_start && rx_ch_ok) begin
            rx_snap[rx_ch] <= rx_in.sig;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_phase <= 3'h0;
        end else if (rx_in.valid && int'(rx_in.channel) == CHANNELS - 1) begin
            rx_phase <= rx_phase + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_out <= '0;
        end else begin
            rx_out.valid   <= rx_in.valid;
            rx_out.channel <= rx_in.channel;
            rx_out.data    <= rx_d;
            rx_out.sig     <= rx_nib;
        end
    end

endmodule

/* File: bench/t1_payload_monitor.sv */
// concurrent checks on the payload control bank ports
`timescale 1ns/1ps
`include "t1_payload_params.svh"
module t1_payload_monitor (
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         hsel,
    input wire logic [31:0]                  haddr,
    input wire logic [1:0]                   htrans,
    input wire logic                         hwrite,
    input wire logic [31:0]                  hwdata,
    input wire logic                         hready,
    input wire logic                         hreadyout,
    input wire logic                         hresp,
    input wire t1_payload_pkg::tx_in_s       tx_in,
    input wire t1_payload_pkg::tx_chan_cfg_s tx_cfg,
    input wire t1_payload_pkg::rx_in_s       rx_in,
    input wire t1_payload_pkg::tx_out_s      tx_out,
    input wire t1_payload_pkg::rx_out_s      rx_out
);
    import t1_payload_pkg::*;
    // ----------------------------------------
    // shadow of the transmit settings, rebuilt from bus writes
    // ----------------------------------------
    logic       wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] cfg;
    logic [7:0] ena;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            wr_idx  <= haddr[9:2];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= `TX_CFG_RESET;
            ena <= `TX_ENABLE_RESET;
        end else if (wr_pend && wr_idx == `IDX_TX_CFG) begin
            cfg <= hwdata[7:0];
        end else if (wr_pend && wr_idx == `IDX_TX_ENABLE) begin
            ena <= hwdata[7:0] & `TX_ENABLE_MASK;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // zero byte on a plain channel, no substitution and no signaling
    sequence plain_zero;
        tx_in.valid && ena[0] && cfg[2:0] == 3'h0 && !tx_in.sig_frame && tx_cfg.chan_sel == 3'h0
            && tx_in.data == 8'h00;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    tx_latency_a: assert property (tx_in.valid |=> tx_out.valid && tx_out.channel == $past(tx_in.channel))
        else $error("transmit output not one cycle after input");
    rx_latency_a: assert property (rx_in.valid |=> rx_out.valid && rx_out.channel == $past(rx_in.channel))
        else $error("receive output not one cycle after input");
    pass_through_a: assert property (tx_in.valid && !ena[0] |=> tx_out.data == $past(tx_in.data))
        else $error("disabled transmit changed data");
    fill8_zero_a: assert property (plain_zero ##0 cfg[5:3] == 3'h1 |=> tx_out.data == 8'h01)
        else $error("bit 8 fill wrong");
    jam_bit_a: assert property (tx_in.valid && ena[0] && cfg[5:3] == 3'h2 |=> tx_out.data[0])
        else $error("bit 8 not forced");
    fill7_zero_a: assert property (plain_zero ##0 cfg[5:3] == 3'h3 |=> tx_out.data == 8'h02)
        else $error("bit 7 fill wrong");
    dds_fill_a: assert property (plain_zero ##0 cfg[5:3] == `SUPP_DDS |=> tx_out.data == `DDS_BYTE)
        else $error("zero byte not replaced");
    trunk_fill_a: assert property (tx_in.valid && ena[0] && cfg[5:0] == 6'h01 && !tx_in.sig_frame
        |=> tx_out.data == $past(tx_cfg.trunk_code)) else $error("trunk code not sent");
endmodule

/* File: bench/t1_host_model.sv */
// bus master model of the microprocessor driving the register bank
`timescale 1ns/1ps
`include "t1_payload_params.svh"
module t1_host_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (!hready);
        rd = hrdata;
    endtask
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, idx, d, r);
    endtask
    task automatic reg_read(input logic [7:0] idx, output logic [31:0] d);
        xfer(1'b0, idx, 8'h00, d);
    endtask
    // no new indirect operation while the engine is busy
    task automatic wait_idle;
        logic [31:0] s;
        s = 32'h1;
        while (s[0]) reg_read(`IDX_RX_STATUS, s);
    endtask
    task automatic ind_write(input logic [6:0] a, input logic [7:0] d);
        wait_idle;
        reg_write(`IDX_RX_DATA, d);
        reg_write(`IDX_RX_CONTROL, {1'b0, a});
    endtask
    task automatic ind_read(input logic [6:0] a, output logic [31:0] d);
        wait_idle;
        reg_write(`IDX_RX_CONTROL, {1'b1, a});
        wait_idle;
        reg_read(`IDX_RX_DATA, d);
    endtask
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the payload control bank
`timescale 1ns/1ps
`include "t1_payload_params.svh"
module tb_top;
    import t1_payload_pkg::*;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hsel, hwrite, hreadyout, hresp, frm, sfs;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic [7:0]  loopback_data, sig_b;
    logic [1:0]  sel;
    tx_in_s       tx_in;
    tx_chan_cfg_s tx_cfg;
    rx_in_s       rx_in;
    tx_out_s      tx_out;
    rx_out_s      rx_out;
    int          error_cnt = 0;
    int          checks = 0;
    always #10 hclk = ~hclk;
    // busy stretched so a status read can still see it
    t1_payload_control_config #(.BUSY_CYCLES(4)) i_t1_payload_control_config (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_in(tx_in),
        .tx_cfg(tx_cfg), .loopback_data(loopback_data), .rx_in(rx_in), .tx_out(tx_out), .rx_out(rx_out));
    t1_host_model i_t1_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        i_t1_host_model.reg_read(idx, r);
        check(r, exp);
    endtask
    task automatic tx_case(input logic [7:0] en, cf, d, input logic sf, input logic [7:0] exp);
        i_t1_host_model.reg_write(`IDX_TX_ENABLE, en);
        i_t1_host_model.reg_write(`IDX_TX_CFG, cf);
        @(posedge hclk);
        tx_in <= '{1'b1, 5'd0, d, sig_b, frm, sfs, sf, sel};
        @(posedge hclk);
        tx_in.valid <= 1'b0;
        #1 check({24'h0, tx_out.data}, {24'h0, exp});
    endtask
    task automatic rx_case(input logic [3:0] s, input logic st, input logic [7:0] d, input logic [11:0] exp);
        @(posedge hclk);
        rx_in <= '{1'b1, 5'd0, d, s, st, 1'b1};
        @(posedge hclk);
        rx_in.valid <= 1'b0;
        #1 check({20'h0, rx_out.data, rx_out.sig}, {20'h0, exp});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_regs;
        rd(`IDX_TX_CFG, 32'h80);
        rd(`IDX_TX_ENABLE, 32'h00);
        rd(`IDX_RX_STATUS, 32'h00);
        rd(`IDX_RX_CONTROL, 32'h00);
        rd(`IDX_RX_DATA, 32'h00);
        rd(`IDX_RX_CFG, 32'h80);
        i_t1_host_model.reg_write(`IDX_TX_ENABLE, 8'hFF);
        rd(`IDX_TX_ENABLE, 32'h09);
        i_t1_host_model.reg_write(`IDX_RX_CFG, 8'hFF);
        rd(`IDX_RX_CFG, 32'hC7);
        i_t1_host_model.reg_write(`IDX_RX_STATUS, 8'hFF);
        rd(`IDX_RX_STATUS, 32'h00);
        i_t1_host_model.reg_write(8'h40, 8'hFF);
        rd(8'h40, 32'h00);
    endtask
    task automatic test_ind;
        logic [31:0] r;
        i_t1_host_model.reg_write(`IDX_RX_DATA, 8'h5A);
        i_t1_host_model.reg_write(`IDX_RX_CONTROL, 8'h21);
        rd(`IDX_RX_STATUS, 32'h01);
        i_t1_host_model.wait_idle;
        rd(`IDX_RX_STATUS, 32'h00);
        i_t1_host_model.reg_write(`IDX_RX_DATA, 8'h00);
        i_t1_host_model.ind_read(7'h21, r);
        check(r, 32'h5A);
        i_t1_host_model.ind_read(7'h19, r);
        check(r, 32'h00);
    endtask
    task test_tx;
        tx_case(8'h00, 8'h10, 8'h00, 1'b0, 8'h00);
        tx_case(8'h01, 8'h00, 8'h00, 1'b0, 8'h00);
        tx_case(8'h01, 8'h08, 8'h00, 1'b0, 8'h01);
        tx_case(8'h01, 8'h08, 8'h00, 1'b1, 8'h02);
        tx_case(8'h01, 8'h10, 8'h40, 1'b0, 8'h41);
        tx_case(8'h01, 8'h18, 8'h00, 1'b0, 8'h02);
        tx_case(8'h01, 8'h18, 8'h10, 1'b0, 8'h10);
        tx_case(8'h01, 8'h20, 8'h00, 1'b0, 8'h98);
        tx_case(8'h01, 8'h01, 8'h33, 1'b0, 8'hA5);
        tx_case(8'h01, 8'h04, 8'h33, 1'b0, 8'h6C);
        tx_case(8'h01, 8'h02, 8'h33, 1'b0, `MW_ALAW_OUTER);
        tx_case(8'h01, 8'h03, 8'h33, 1'b0, `MW_ULAW_OUTER);
        sel = 2'd3;
        tx_case(8'h01, 8'h40, 8'h80, 1'b1, 8'h81);
        @(posedge hclk);
        tx_cfg.chan_sel <= 3'h1;
        tx_case(8'h01, 8'h00, 8'h33, 1'b0, 8'hA5);
        @(posedge hclk);
        tx_cfg.chan_sel <= 3'h0;
        sel = 2'd0;
        frm = 1'b1;
        sfs = 1'b1;
        sig_b = 8'h08;
        tx_case(8'h01, 8'h80, 8'h00, 1'b1, 8'h01);
        sfs = 1'b0;
        sig_b = 8'h02;
        tx_case(8'h01, 8'h80, 8'h00, 1'b1, 8'h01);
        sel = 2'd2;
        tx_case(8'h01, 8'h00, 8'h00, 1'b1, 8'h01);
        tx_case(8'h09, 8'h00, 8'h00, 1'b1, 8'h00);
    endtask
    task test_rx;
        i_t1_host_model.reg_write(`IDX_RX_CFG, 8'h80);
        rx_case(4'h5, 1'b1, 8'h11, 12'h115);
        rx_case(4'hA, 1'b0, 8'h22, 12'h225);
        i_t1_host_model.reg_write(`IDX_RX_CFG, 8'h01);
        rx_case(4'h3, 1'b0, 8'h11, 12'h5A3);
    endtask
    initial begin
        hresetn = 1'b0;
        tx_in = '0;
        rx_in = '0;
        tx_cfg = '{3'h0, 8'hA5, 1'b0, 4'h1};
        loopback_data = 8'h6C;
        sig_b = 8'h00;
        frm = 1'b0;
        sfs = 1'b0;
        sel = 2'd0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        test_regs;
        test_ind;
        test_tx;
        test_rx;
        stop_test;
    end
    // the whole sequence takes well under two thousand cycles
    initial begin
        repeat (6000) @(posedge hclk);
        error_cnt++;
        stop_test;
    end
endmodule
bind t1_payload_control_config t1_payload_monitor i_t1_payload_monitor (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .tx_in(tx_in), .tx_cfg(tx_cfg), .rx_in(rx_in),
    .tx_out(tx_out), .rx_out(rx_out));
